// File: adc_cfg_pkg.sv
/*
 * Shared constants for the converter mode/clock configuration bank:
 * register indices, field positions, reset values, timing and decoders.
 * Assumes a single 100 MHz register clock.
 */
package adc_cfg_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned READY_PULSE_NS     = 40;
   localparam int unsigned READY_PULSE_CYCLES =
      (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SERIAL_TIMEOUT_NS  = 1000000;
   localparam int unsigned SERIAL_TIMEOUT_CYCLES =
      SERIAL_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_W          = 20;
   localparam int unsigned PULSE_W            = 4;

   // Bus layout; register index sits at address bits 7:2
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned IDX_LO     = 2;
   localparam logic [5:0]  STATUS_IDX = 6'h01;
   localparam logic [5:0]  MODE_IDX   = 6'h02;
   localparam logic [5:0]  CLOCK_IDX  = 6'h03;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Reset values and writable masks
   localparam logic [15:0] MODE_RESET    = 16'h0510;
   localparam logic [15:0] CLOCK_RESET   = 16'hFF0E;
   localparam logic [15:0] MODE_WRITABLE = 16'h3FFF;

   // Mode fields
   localparam int unsigned MODE_REGMAP_CHECK = 13;
   localparam int unsigned MODE_INPUT_CHECK  = 12;
   localparam int unsigned MODE_POLY         = 11;
   localparam int unsigned MODE_RESET_BIT    = 10;
   localparam int unsigned MODE_WLEN_LO      = 8;
   localparam int unsigned MODE_GUARD        = 4;
   localparam int unsigned MODE_SRC_LO       = 2;
   localparam int unsigned MODE_FLOAT        = 1;
   localparam int unsigned MODE_PULSE        = 0;

   // Clock fields
   localparam int unsigned CLK_EN_LO  = 8;
   localparam int unsigned CLK_XTAL   = 7;
   localparam int unsigned CLK_VREF   = 6;
   localparam int unsigned CLK_OSR_LO = 2;
   localparam int unsigned CLK_PWR_LO = 0;

   // Status fields
   localparam int unsigned STAT_FAULT   = 12;
   localparam int unsigned STAT_POLY    = 11;
   localparam int unsigned STAT_RESET   = 10;
   localparam int unsigned STAT_WLEN_LO = 8;

   // Ready source codes
   localparam logic [1:0] SRC_LAGGING = 2'h0;
   localparam logic [1:0] SRC_ANY     = 2'h1;

   // Oversampling ratio
   localparam logic [2:0]  OSR_TOP_CODE = 3'h7;
   localparam logic [13:0] OSR_BASE     = 14'h0080;
   localparam logic [13:0] OSR_TOP      = 14'h3F80;

   function automatic logic [13:0] osr_factor(input logic [2:0] code);
      if (code == OSR_TOP_CODE) begin
         return OSR_TOP;
      end
      return OSR_BASE << code;
   endfunction

endpackage

// File: adc_mode_clock_config_regs.sv
/*
 * Mode and clock/channel configuration bank of an eight-channel
 * converter, with status flags, reached over AXI4-Lite.
 * Assumes event inputs come from logic on aclk; the pin is resolved
 * from out/oe by the surrounding wrapper.
 */
`timescale 1ns/100ps
module adc_mode_clock_config_regs #(
   parameter int unsigned TIMEOUT_CYCLES =
      adc_cfg_pkg::SERIAL_TIMEOUT_CYCLES
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Converter events
   input  wire logic [7:0]  channel_new_data,
   input  wire logic        data_frame_read,
   input  wire logic        frame_check_fail,
   input  wire logic        serial_frame_active,
   // Configuration outputs
   output logic             regmap_check_enable,
   output logic             input_check_enable,
   output logic             check_polynomial_select,
   output logic [1:0]       sample_word_size,
   output logic             serial_inactivity_guard,
   output logic [7:0]       channel_run_enable,
   output logic             crystal_osc_off,
   output logic             outside_vref_select,
   output logic [2:0]       oversample_ratio,
   output logic [13:0]      oversample_factor,
   output logic [1:0]       power_profile,
   output logic             serial_timeout,
   // Ready pin
   output logic             sample_ready_pin_out,
   output logic             sample_ready_pin_oe
);

   typedef struct packed {
      logic [15:0]                          mode;
      logic [15:0]                          clk;
      logic                                 reset_flag;
      logic                                 check_fault;
      logic [7:0]                           ready_flags;
      logic                                 avail;
      logic [13:0]                          osr;
      logic                                 awready;
      logic                                 wready;
      logic [5:0]                           aw_idx;
      logic [15:0]                          w_data;
      logic [1:0]                           w_strb;
      logic                                 bvalid;
      logic [1:0]                           bresp;
      logic                                 arready;
      logic                                 rvalid;
      logic [31:0]                          rdata;
      logic [1:0]                           rresp;
      logic [adc_cfg_pkg::TIMEOUT_W-1:0]    idle_count;
      logic                                 timeout_hit;
   } regs_s;

   regs_s s;
   regs_s next_s;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] data,
                                         input logic [1:0]  strb,
                                         input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~lanes) | (data & lanes);
   endfunction

   // Ready source across enabled channels
   function automatic logic ready_source(input logic [1:0] sel,
                                         input logic [7:0] flags,
                                         input logic [7:0] en);
      logic [7:0] lead;
      lead = en & (~en + 8'h01);
      if (en == 8'h00) begin
         return 1'b0;
      end
      if (sel == adc_cfg_pkg::SRC_LAGGING) begin
         return (flags & en) == en;
      end
      if (sel == adc_cfg_pkg::SRC_ANY) begin
         return |(flags & en);
      end
      return |(flags & lead);
   endfunction

   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        wr_fire;
   logic [5:0]  ar_idx;
   logic [5:0]  wr_idx;
   logic [15:0] wr_data;
   logic [1:0]  wr_strb;
   logic [15:0] status_word;
   logic [7:0]  run_en;

   always_comb begin
      aw_take = awvalid && s.awready;
      w_take  = wvalid && s.wready;
      ar_take = arvalid && s.arready;
      wr_idx  = aw_take ? awaddr[adc_cfg_pkg::IDX_LO +: 6] : s.aw_idx;
      wr_data = w_take ? wdata[15:0] : s.w_data;
      wr_strb = w_take ? wstrb[1:0] : s.w_strb;
      ar_idx  = araddr[adc_cfg_pkg::IDX_LO +: 6];
      run_en  = s.clk[adc_cfg_pkg::CLK_EN_LO +: 8];
      // Both halves of a write held and no response outstanding
      wr_fire = (!s.awready || aw_take) && (!s.wready || w_take)
                && !s.bvalid;
      status_word = '0;
      status_word[adc_cfg_pkg::STAT_FAULT]  = s.check_fault;
      status_word[adc_cfg_pkg::STAT_POLY]   =
         s.mode[adc_cfg_pkg::MODE_POLY];
      status_word[adc_cfg_pkg::STAT_RESET]  = s.reset_flag;
      status_word[adc_cfg_pkg::STAT_WLEN_LO +: 2] =
         s.mode[adc_cfg_pkg::MODE_WLEN_LO +: 2];
      status_word[7:0] = s.ready_flags;
   end

   always_comb begin
      next_s = s;
      if (aw_take) begin
         next_s.awready = 1'b0;
         next_s.aw_idx  = wr_idx;
      end
      if (w_take) begin
         next_s.wready = 1'b0;
         next_s.w_data = wr_data;
         next_s.w_strb = wr_strb;
      end
      if (wr_fire) begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = adc_cfg_pkg::RESP_OKAY;
         if (wr_idx == adc_cfg_pkg::MODE_IDX) begin
            // Bits 15:14 never store; 7:5 kept as written
            next_s.mode = merge(s.mode, wr_data, wr_strb,
                                adc_cfg_pkg::MODE_WRITABLE);
            if (wr_strb[1] && !wr_data[adc_cfg_pkg::MODE_RESET_BIT]) begin
               next_s.reset_flag = 1'b0;
            end
         end else if (wr_idx == adc_cfg_pkg::CLOCK_IDX) begin
            next_s.clk = merge(s.clk, wr_data, wr_strb, '1);
         end else begin
            // Status is read-only; unmapped writes are refused
            next_s.bresp = adc_cfg_pkg::RESP_SLVERR;
         end
      end
      if (s.bvalid && bready) begin
         next_s.bvalid  = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready  = 1'b1;
      end
      if (ar_take) begin
         next_s.arready = 1'b0;
         next_s.rvalid  = 1'b1;
         next_s.rresp   = adc_cfg_pkg::RESP_OKAY;
         next_s.rdata   = '0;
         unique case (ar_idx)
            adc_cfg_pkg::STATUS_IDX: begin
               next_s.rdata[15:0]  = status_word;
               next_s.check_fault  = 1'b0;
            end
            adc_cfg_pkg::MODE_IDX:  next_s.rdata[15:0] = s.mode;
            adc_cfg_pkg::CLOCK_IDX: next_s.rdata[15:0] = s.clk;
            default: next_s.rresp = adc_cfg_pkg::RESP_SLVERR;
         endcase
      end
      if (s.rvalid && rready) begin
         next_s.rvalid  = 1'b0;
         next_s.arready = 1'b1;
      end
      // Events win over a clear in the same cycle
      if (frame_check_fail && s.mode[adc_cfg_pkg::MODE_INPUT_CHECK]) begin
         next_s.check_fault = 1'b1;
      end
      if (data_frame_read) begin
         next_s.ready_flags = '0;
      end
      next_s.ready_flags = next_s.ready_flags
                           | (channel_new_data & run_en);
      next_s.avail = ready_source(s.mode[adc_cfg_pkg::MODE_SRC_LO +: 2],
                                  s.ready_flags, run_en);
      next_s.osr = adc_cfg_pkg::osr_factor(
                      s.clk[adc_cfg_pkg::CLK_OSR_LO +: 3]);
      next_s.timeout_hit = 1'b0;
      if (s.mode[adc_cfg_pkg::MODE_GUARD] && serial_frame_active) begin
         // Long count kept as a parameter so benches can shorten it
         if (s.idle_count == adc_cfg_pkg::TIMEOUT_W'(TIMEOUT_CYCLES - 1))
         begin
            next_s.idle_count  = '0;
            next_s.timeout_hit = 1'b1;
         end else begin
            next_s.idle_count = s.idle_count + 1'b1;
         end
      end else begin
         next_s.idle_count = '0;
      end
      if (!aresetn) begin
         next_s             = '0;
         next_s.mode        = adc_cfg_pkg::MODE_RESET;
         next_s.clk         = adc_cfg_pkg::CLOCK_RESET;
         next_s.reset_flag  = 1'b1;
         next_s.osr         = adc_cfg_pkg::osr_factor(
            adc_cfg_pkg::CLOCK_RESET[adc_cfg_pkg::CLK_OSR_LO +: 3]);
         next_s.awready     = 1'b1;
         next_s.wready      = 1'b1;
         next_s.arready     = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   ready_pin_driver u_ready_pin (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .data_available (s.avail),
      .idle_float     (s.mode[adc_cfg_pkg::MODE_FLOAT]),
      .pulse_style    (s.mode[adc_cfg_pkg::MODE_PULSE]),
      .pin_out        (sample_ready_pin_out),
      .pin_oe         (sample_ready_pin_oe)
   );

   assign awready = s.awready;
   assign wready  = s.wready;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign arready = s.arready;
   assign rvalid  = s.rvalid;
   assign rdata   = s.rdata;
   assign rresp   = s.rresp;
   assign regmap_check_enable     =
      s.mode[adc_cfg_pkg::MODE_REGMAP_CHECK];
   assign input_check_enable      =
      s.mode[adc_cfg_pkg::MODE_INPUT_CHECK];
   assign check_polynomial_select = s.mode[adc_cfg_pkg::MODE_POLY];
   assign sample_word_size        =
      s.mode[adc_cfg_pkg::MODE_WLEN_LO +: 2];
   assign serial_inactivity_guard = s.mode[adc_cfg_pkg::MODE_GUARD];
   assign channel_run_enable      = run_en;
   assign crystal_osc_off         = s.clk[adc_cfg_pkg::CLK_XTAL];
   assign outside_vref_select     = s.clk[adc_cfg_pkg::CLK_VREF];
   assign oversample_ratio        = s.clk[adc_cfg_pkg::CLK_OSR_LO +: 3];
   assign oversample_factor       = s.osr;
   assign power_profile           =
      s.clk[adc_cfg_pkg::CLK_PWR_LO +: 2];
   assign serial_timeout          = s.timeout_hit;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   mode_reset_a: assert property (disable iff (1'b0)
      !aresetn |=> s.mode == adc_cfg_pkg::MODE_RESET && s.reset_flag)
      else $error("mode register reset value wrong");
   clock_reset_a: assert property (disable iff (1'b0)
      !aresetn |=> s.clk == adc_cfg_pkg::CLOCK_RESET)
      else $error("clock register reset value wrong");
   flag_clear_a: assert property (
      wr_fire && wr_idx == adc_cfg_pkg::MODE_IDX && wr_strb[1]
      && !wr_data[adc_cfg_pkg::MODE_RESET_BIT] |=> !s.reset_flag)
      else $error("reset flag not cleared by mode write");
   flag_sticky_a: assert property (
      !s.reset_flag |=> !s.reset_flag)
      else $error("reset flag set without reset");
   fault_set_a: assert property (
      frame_check_fail && input_check_enable |=> s.check_fault)
      else $error("checksum fault not flagged");
   new_data_a: assert property (
      |(channel_new_data & run_en)
      |=> (s.ready_flags & $past(channel_new_data & run_en))
          == $past(channel_new_data & run_en))
      else $error("channel ready flag missed");
   osr_decode_a: assert property (
      $stable(oversample_ratio)[*2] |-> oversample_factor
         == adc_cfg_pkg::osr_factor(oversample_ratio))
      else $error("oversampling factor mismatch");
   bresp_hold_a: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   timeout_gate_a: assert property (
      !serial_inactivity_guard |=> !serial_timeout)
      else $error("timeout while guard disabled");
   mode_write_c: cover property (wr_fire && wr_idx == adc_cfg_pkg::MODE_IDX);
   bad_read_c: cover property (rvalid && rresp == adc_cfg_pkg::RESP_SLVERR);
   timeout_c: cover property (serial_timeout);

endmodule

// File: conv_event_model.sv
/* Converter-side event source for the configuration bank.
   Assumes it runs on the same aclk as the bank. */
`timescale 1ns/100ps
module conv_event_model (
   // Clock
   input  wire logic aclk,
   // Events toward the bank
   output logic [7:0] channel_new_data,
   output logic       data_frame_read,
   output logic       frame_check_fail,
   output logic       serial_frame_active
);
   initial begin
      channel_new_data    = 8'h00;
      data_frame_read     = 1'b0;
      frame_check_fail    = 1'b0;
      serial_frame_active = 1'b0;
   end
   // Single-cycle pulses so each event counts once; frame level persists
   task automatic ev(input logic [7:0] nd, input logic rd,
                     input logic fl, input logic fa);
      @(posedge aclk);
      channel_new_data    <= nd;
      data_frame_read     <= rd;
      frame_check_fail    <= fl;
      serial_frame_active <= fa;
      @(posedge aclk);
      channel_new_data <= 8'h00;
      data_frame_read  <= 1'b0;
      frame_check_fail <= 1'b0;
   endtask
endmodule

// File: ready_pin_driver.sv
/*
 * Drives the sample-ready pin: held low, single fixed low pulse,
 * idle high or released. Inputs come from same-clock logic.
 */
`timescale 1ns/100ps
module ready_pin_driver (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control
   input  wire logic data_available,
   input  wire logic idle_float,
   input  wire logic pulse_style,
   // Pin
   output logic      pin_out,
   output logic      pin_oe
);

   typedef enum logic [1:0] {IDLE, HOLD_LOW, PULSE, SPENT} pin_state_e;

   typedef struct packed {
      pin_state_e                              state;
      logic [adc_cfg_pkg::PULSE_W-1:0]         count;
      logic                                    out;
      logic                                    oe;
   } pin_s;

   pin_s s;
   pin_s next_s;

   always_comb begin
      next_s = s;
      unique case (s.state)
         IDLE, SPENT: begin
            if (!data_available) begin
               next_s.state = IDLE;
            end else if (!pulse_style) begin
               next_s.state = HOLD_LOW;
            end else if (s.state == IDLE) begin
               next_s.state = PULSE;
               next_s.count = '0;
            end
         end
         HOLD_LOW: begin
            if (!data_available || pulse_style) begin
               next_s.state = data_available ? SPENT : IDLE;
            end
         end
         PULSE: begin
            next_s.count = s.count + 1'b1;
            if (s.count == adc_cfg_pkg::PULSE_W'(
                   adc_cfg_pkg::READY_PULSE_CYCLES - 1)) begin
               next_s.state = SPENT;
            end
         end
      endcase
      // Outside the low phase the pin idles high or floats
      if (next_s.state == HOLD_LOW || next_s.state == PULSE) begin
         next_s.out = 1'b0;
         next_s.oe  = 1'b1;
      end else begin
         next_s.out = 1'b1;
         next_s.oe  = !idle_float;
      end
      if (!aresetn) begin
         next_s.state = IDLE;
         next_s.count = '0;
         next_s.out   = 1'b1;
         next_s.oe    = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   assign pin_out = s.out;
   assign pin_oe  = s.oe;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire in_pulse = (s.state == PULSE);

   hold_low_a: assert property (
      data_available && !pulse_style |=> !pin_out && pin_oe)
      else $error("pin not held low while data available");
   pulse_width_a: assert property (
      $rose(in_pulse) |-> in_pulse[*4] ##1 !in_pulse)
      else $error("ready pulse width wrong");
   idle_float_a: assert property (
      !data_available && idle_float |=> !pin_oe)
      else $error("pin driven while idle floating");
   pulse_seen_c: cover property ($rose(in_pulse));

endmodule

// File: tb_adc_mode_clock_config_regs.sv
/* Bench for the mode/clock configuration bank: AXI4-Lite access task,
   register, event and ready-pin sequences.
   Assumes conv_event_model drives the converter events on aclk. */
`timescale 1ns/100ps
module tb_adc_mode_clock_config_regs;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_word;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, sample_word_size, power_profile;
   logic [7:0]  channel_new_data, channel_run_enable;
   logic        data_frame_read, frame_check_fail, serial_frame_active;
   logic        regmap_check_enable, input_check_enable, serial_timeout;
   logic        check_polynomial_select, serial_inactivity_guard;
   logic        crystal_osc_off, outside_vref_select;
   logic        sample_ready_pin_out, sample_ready_pin_oe;
   logic [2:0]  oversample_ratio;
   logic [13:0] oversample_factor;
   logic [15:0] d;
   int          num_errors = 0, checked = 0, n;

   always #5 aclk = ~aclk;

   // Short timeout keeps the run small
   adc_mode_clock_config_regs #(
      .TIMEOUT_CYCLES(16)
   ) u_adc_mode_clock_config_regs (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .channel_new_data,
      .data_frame_read, .frame_check_fail, .serial_frame_active,
      .regmap_check_enable, .input_check_enable, .check_polynomial_select,
      .sample_word_size, .serial_inactivity_guard, .channel_run_enable,
      .crystal_osc_off, .outside_vref_select, .oversample_ratio,
      .oversample_factor, .power_profile, .serial_timeout,
      .sample_ready_pin_out, .sample_ready_pin_oe
   );
   conv_event_model u_conv_event_model (
      .aclk, .channel_new_data, .data_frame_read, .frame_check_fail,
      .serial_frame_active
   );

   task automatic stop_test();
      if (num_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One write (w=1) or read; handshakes judged from pre-edge values
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [15:0] dv, input logic [1:0] er);
      logic       ta, tw, tr, hb;
      logic [1:0] r;
      int         k;
      @(posedge aclk);
      awaddr  <= a;
      araddr  <= a;
      wdata   <= {16'h0000, dv};
      wstrb   <= 4'h3;
      awvalid <= w;
      wvalid  <= w;
      bready  <= w;
      arvalid <= !w;
      rready  <= !w;
      k = 0;
      do begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tr = arvalid && arready;
         hb = (bvalid && bready) || (rvalid && rready);
         r = w ? bresp : rresp;
         rd_word = rdata;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         k++;
      end while (hb !== 1'b1 && k < 50);
      bready <= 1'b0;
      rready <= 1'b0;
      if (hb !== 1'b1) begin
         chk("handshake", 32'h1, 32'h0);
         stop_test();
      end
      chk("resp", 32'(er), 32'(r));
      if (!w) chk("rdata", 32'(dv), rd_word);
   endtask

   // Availability and pin each lag one cycle
   task automatic pin(input logic eo, input logic eoe);
      repeat (3) @(negedge aclk);
      chk("pin_out", 32'(eo), 32'(sample_ready_pin_out));
      chk("pin_oe", 32'(eoe), 32'(sample_ready_pin_oe));
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      pin(1'b1, 1'b1);
      acc(1'b0, 8'h08, 16'h0510, 2'h0);
      acc(1'b0, 8'h0C, 16'hFF0E, 2'h0);
      acc(1'b0, 8'h04, 16'h0500, 2'h0);
      acc(1'b0, 8'h10, 16'h0000, 2'h2);
      acc(1'b1, 8'h04, 16'h0000, 2'h2);
      acc(1'b1, 8'h08, 16'hFE0D, 2'h0);
      acc(1'b0, 8'h08, 16'h3E0D, 2'h0);
      chk("regmap", 32'h1, 32'(regmap_check_enable));
      chk("incheck", 32'h1, 32'(input_check_enable));
      chk("poly", 32'h1, 32'(check_polynomial_select));
      chk("guard", 32'h0, 32'(serial_inactivity_guard));
      acc(1'b0, 8'h04, 16'h0E00, 2'h0);
      for (int i = 0; i < 4; i++) begin
         d = 16'h0410 | (16'(i) << 8);
         acc(1'b1, 8'h08, d, 2'h0);
         chk("size", i, 32'(sample_word_size));
         acc(1'b0, 8'h04, d & 16'h0700, 2'h0);
      end
      acc(1'b1, 8'h08, 16'h0110, 2'h0);
      acc(1'b1, 8'h08, 16'h0510, 2'h0);
      acc(1'b0, 8'h04, 16'h0100, 2'h0);
      for (int i = 0; i < 8; i++) begin
         d = {~(8'h01 << i), i[0], i[1], 1'b0, i[2:0], i[1:0]};
         acc(1'b1, 8'h0C, d, 2'h0);
         acc(1'b0, 8'h0C, d, 2'h0);
         chk("osr", i == 7 ? 16256 : 128 << i,
             32'(oversample_factor));
         chk("osr code", i, 32'(oversample_ratio));
         chk("power", i % 4, 32'(power_profile));
         chk("chan", 32'(d[15:8]), 32'(channel_run_enable));
         chk("xtal", i % 2, 32'(crystal_osc_off));
         chk("vref", (i / 2) % 2, 32'(outside_vref_select));
      end
      acc(1'b1, 8'h0C, 16'hFC0E, 2'h0);
      u_conv_event_model.ev(8'h05, 1'b0, 1'b1, 1'b0);
      acc(1'b0, 8'h04, 16'h0104, 2'h0);
      pin(1'b1, 1'b1);
      acc(1'b1, 8'h08, 16'h0518, 2'h0);
      pin(1'b0, 1'b1);
      u_conv_event_model.ev(8'h08, 1'b1, 1'b0, 1'b0);
      pin(1'b1, 1'b1);
      acc(1'b0, 8'h04, 16'h0108, 2'h0);
      acc(1'b1, 8'h08, 16'h0514, 2'h0);
      pin(1'b0, 1'b1);
      acc(1'b1, 8'h08, 16'h0510, 2'h0);
      pin(1'b1, 1'b1);
      u_conv_event_model.ev(8'hFC, 1'b0, 1'b0, 1'b0);
      pin(1'b0, 1'b1);
      u_conv_event_model.ev(8'h00, 1'b1, 1'b0, 1'b0);
      acc(1'b1, 8'h08, 16'h0512, 2'h0);
      pin(1'b1, 1'b0);
      acc(1'b1, 8'h08, 16'h0517, 2'h0);
      u_conv_event_model.ev(8'h04, 1'b0, 1'b0, 1'b0);
      n = 0;
      repeat (12) begin
         @(negedge aclk);
         if (sample_ready_pin_out === 1'b0) n++;
      end
      chk("pulse", adc_cfg_pkg::READY_PULSE_CYCLES, n);
      chk("pin_oe", 32'h0, 32'(sample_ready_pin_oe));
      acc(1'b1, 8'h08, 16'h1517, 2'h0);
      u_conv_event_model.ev(8'h00, 1'b0, 1'b1, 1'b1);
      acc(1'b0, 8'h04, 16'h1104, 2'h0);
      acc(1'b0, 8'h04, 16'h0104, 2'h0);
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (serial_timeout !== 1'b1 && n < 40);
      chk("timeout", 32'h1, 32'(serial_timeout));
      acc(1'b1, 8'h08, 16'h1507, 2'h0);
      n = 0;
      repeat (40) begin
         @(negedge aclk);
         if (serial_timeout === 1'b1) n++;
      end
      chk("timeout off", 32'h0, n);
      u_conv_event_model.ev(8'h00, 1'b0, 1'b0, 1'b0);
      // Second reset mid-run must reload every register
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      pin(1'b1, 1'b1);
      acc(1'b0, 8'h08, 16'h0510, 2'h0);
      acc(1'b0, 8'h0C, 16'hFF0E, 2'h0);
      acc(1'b0, 8'h04, 16'h0500, 2'h0);
      chk("regmap", 32'h0, 32'(regmap_check_enable));
      chk("guard", 32'h1, 32'(serial_inactivity_guard));
      stop_test();
   end
endmodule
